// ==== logic/bldcs_pkg.sv ====
// Shared constants and types for the start-up and commutation sequencer.
// Assumes one 100 MHz core clock and a synchronous active-high reset.
package bldcs_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int OFF_TIME_NS = 20000;
  localparam int OFF_TIME_CYCLES = (OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_CNT_W = 16;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int ADR_W = 8;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADR_IRQ_CLEAR = 8'h0C;
  localparam logic [7:0] ADR_IRQ_ENABLE = 8'h10;
  localparam int CTRL_RESTART_BIT = 0;
  localparam int ST_PHASE_LSB = 0;
  localparam int ST_COMM_LSB = 2;
  localparam int ST_BRAKE_BIT = 5;
  localparam int ST_UV_BIT = 6;
  localparam int ST_DIR_BIT = 7;
  localparam int ST_LC_BLOCK_BIT = 8;
  localparam int ST_LIMIT_BIT = 9;
  localparam int EV_N = 5;
  localparam int EV_RAMP = 0;
  localparam int EV_RUN = 1;
  localparam int EV_TRIP = 2;
  localparam int EV_UV = 3;
  localparam int EV_BRAKE = 4;
  localparam logic [EV_N-1:0] IRQ_ENABLE_RST = 5'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    PH_ALIGN = 2'b00,
    PH_RAMP = 2'b01,
    PH_RUN = 2'b10
  } bldcs_phase_t;

  typedef enum logic [2:0] {
    CS_A = 3'b000,
    CS_B = 3'b001,
    CS_C = 3'b010,
    CS_D = 3'b011,
    CS_E = 3'b100,
    CS_F = 3'b101
  } bldcs_comm_t;

  // Bit 0 phase A, bit 1 phase B, bit 2 phase C
  typedef struct packed {
    logic [2:0] low;
    logic [2:0] high_n;
  } bldcs_drive_t;

  typedef struct packed {
    logic align_cap_clear;
    logic commutation_clock;
    logic pwm;
    logic supply_low;
    logic current_trip;
    logic hc_off;
    logic ramp_done;
    logic align_done;
    logic dir;
    logic brake_n;
  } bldcs_pins_t;

  localparam int PINS_W = 10;
  localparam bldcs_pins_t PINS_RST = 10'h003;
  localparam bldcs_drive_t DRIVE_ALIGN = 6'h12;
  localparam bldcs_drive_t DRIVE_BRAKE = 6'h3F;
  localparam bldcs_drive_t DRIVE_OFF = 6'h07;

endpackage

// ==== logic/bldcs_sync.sv ====
// Three-stage pin synchroniser with a two-stage agreement filter.
// Assumes inputs are asynchronous to i_core_clk.
`timescale 1ns/1ps
`default_nettype none
module bldcs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);

  // ****************************************
  // Per-bit stages
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic lvl_ff;
      always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
          s1_ff <= RST_VAL[g];
          s2_ff <= RST_VAL[g];
          s3_ff <= RST_VAL[g];
        end else begin
          s1_ff <= i_async[g];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
        end
      end
      // Level moves only once stages two and three agree
      always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
          lvl_ff <= RST_VAL[g];
        end else if (s2_ff == s3_ff) begin
          lvl_ff <= s3_ff;
        end
      end
      assign o_level[g] = lvl_ff;
    end
  endgenerate

endmodule
`default_nettype wire

// ==== logic/bldcs_oneshot.sv ====
// Current-limit off-time one-shot.
// Assumes i_fire is already synchronous; retriggers while active are ignored.
`timescale 1ns/1ps
`default_nettype none
module bldcs_oneshot #(
  parameter int CYCLES = bldcs_pkg::OFF_TIME_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_fire,
  output logic o_active
);

  // ****************************************
  // Off-time counter
  // ****************************************
  localparam logic [bldcs_pkg::OFF_CNT_W-1:0] LOAD = bldcs_pkg::OFF_CNT_W'(CYCLES - 1);
  logic [bldcs_pkg::OFF_CNT_W-1:0] cnt_ff;
  logic active_ff;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      active_ff <= 1'b0;
      cnt_ff <= '0;
    end else if (!active_ff && i_fire) begin
      active_ff <= 1'b1;
      cnt_ff <= LOAD;
    end else if (active_ff) begin
      if (cnt_ff == '0) begin
        active_ff <= 1'b0;
      end else begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  assign o_active = active_ff;

  a_off_time_held: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $rose(active_ff) |-> (cnt_ff == LOAD)) else $error("off-time not loaded");

endmodule
`default_nettype wire

// ==== logic/bldcs_top.sv ====
// Start-up sequencer, commutation state machine and driver gating.
// Assumes all comparator and control inputs arrive asynchronously on pins,
// a classic Wishbone master on the core clock, and a half-bridge stage outside.
//
// Notes on behaviour
// - Reset enters alignment before any commutation.
// - Alignment holds LB on, HA and HC on.
// - Align comparator trip moves to ramp.
// - Ramp steps states A to F per clock.
// - Back-EMF sampling disabled during ramp.
// - Ramp comparator trip moves to run.
// - Run enables back-EMF, clock advances states.
// - Low sides gated by PWM and one-shot.
// - LC held off until HC turned off.
// - Brake turns lows on, highs off.
// - Brake disables current-limit gating.
// - Supply low drives fault flag low.
// - Undervoltage turns all six drivers off.
// - Current trip forces lows off for off-time.
// - Direction low reverses sequence; change when stopped.
// - Forward table of low and high pairs.
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module bldcs_top #(
  parameter int OFF_CYCLES = bldcs_pkg::OFF_TIME_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [bldcs_pkg::ADR_W-1:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_irq,
  input wire logic i_brake_n,
  input wire logic i_dir,
  input wire logic i_align_done,
  input wire logic i_ramp_done,
  input wire logic i_hc_off,
  input wire logic i_current_trip,
  input wire logic i_supply_low,
  input wire logic i_pwm,
  input wire logic i_commutation_clock,
  input wire logic i_align_cap_clear,
  output logic o_low_drive_phase_a,
  output logic o_low_drive_phase_b,
  output logic o_low_drive_phase_c,
  output logic o_high_drive_phase_a_n,
  output logic o_high_drive_phase_b_n,
  output logic o_high_drive_phase_c_n,
  output logic o_supply_low_flag_n,
  output logic o_bemf_enable,
  output logic [2:0] o_bemf_sense_phase
);

  // ****************************************
  // Pin synchronisation
  // ****************************************
  bldcs_pkg::bldcs_pins_t pins_raw;
  bldcs_pkg::bldcs_pins_t pins;
  assign pins_raw = '{align_cap_clear: i_align_cap_clear, commutation_clock: i_commutation_clock,
                      pwm: i_pwm, supply_low: i_supply_low, current_trip: i_current_trip,
                      hc_off: i_hc_off, ramp_done: i_ramp_done, align_done: i_align_done,
                      dir: i_dir, brake_n: i_brake_n};

  bldcs_sync #(
    .W(bldcs_pkg::PINS_W),
    .RST_VAL(bldcs_pkg::PINS_RST)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_async(pins_raw),
    .o_level(pins)
  );

  logic brake;
  logic uv;
  logic clk_prev_ff;
  logic trip_prev_ff;
  logic uv_prev_ff;
  logic brake_prev_ff;
  logic clk_rise;
  logic trip_rise;
  assign brake = !pins.brake_n;
  assign uv = pins.supply_low;
  assign clk_rise = pins.commutation_clock && !clk_prev_ff;
  assign trip_rise = pins.current_trip && !trip_prev_ff;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      clk_prev_ff <= 1'b0;
      trip_prev_ff <= 1'b0;
      uv_prev_ff <= 1'b0;
      brake_prev_ff <= 1'b0;
    end else begin
      clk_prev_ff <= pins.commutation_clock;
      trip_prev_ff <= pins.current_trip;
      uv_prev_ff <= uv;
      brake_prev_ff <= brake;
    end
  end

  // ****************************************
  // Wishbone slave
  // ****************************************
  logic ack_ff;
  logic [31:0] dat_ff;
  logic wr_take;
  logic restart;
  logic [bldcs_pkg::EV_N-1:0] irq_status_ff;
  logic [bldcs_pkg::EV_N-1:0] irq_enable_ff;
  logic [bldcs_pkg::EV_N-1:0] events;
  logic [31:0] status_word;
  logic [31:0] nxt_dat;
  bldcs_pkg::bldcs_phase_t phase_ff;
  bldcs_pkg::bldcs_comm_t comm_ff;
  logic lc_block_ff;
  logic limit_active;

  // Write lands on the edge where the master sees ack
  assign wr_take = i_wb_cyc && i_wb_stb && i_wb_we && ack_ff && i_wb_sel[0];

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= i_wb_cyc && i_wb_stb && !ack_ff;
    end
  end

  always_comb begin
    status_word = '0;
    status_word[bldcs_pkg::ST_PHASE_LSB +: 2] = phase_ff;
    status_word[bldcs_pkg::ST_COMM_LSB +: 3] = comm_ff;
    status_word[bldcs_pkg::ST_BRAKE_BIT] = brake;
    status_word[bldcs_pkg::ST_UV_BIT] = uv;
    status_word[bldcs_pkg::ST_DIR_BIT] = pins.dir;
    status_word[bldcs_pkg::ST_LC_BLOCK_BIT] = lc_block_ff;
    status_word[bldcs_pkg::ST_LIMIT_BIT] = limit_active;
    case (i_wb_adr)
      bldcs_pkg::ADR_STATUS: nxt_dat = status_word;
      bldcs_pkg::ADR_IRQ_STATUS: nxt_dat = {27'h0000000, irq_status_ff};
      bldcs_pkg::ADR_IRQ_ENABLE: nxt_dat = {27'h0000000, irq_enable_ff};
      default: nxt_dat = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      dat_ff <= 32'h00000000;
    end else if (i_wb_cyc && i_wb_stb && !ack_ff) begin
      dat_ff <= nxt_dat;
    end
  end

  assign o_wb_ack = ack_ff;
  assign o_wb_dat = dat_ff;

  // ****************************************
  // Interrupts
  // ****************************************
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      irq_enable_ff <= bldcs_pkg::IRQ_ENABLE_RST;
    end else if (wr_take && i_wb_adr == bldcs_pkg::ADR_IRQ_ENABLE) begin
      irq_enable_ff <= i_wb_dat[bldcs_pkg::EV_N-1:0];
    end
  end

  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      irq_status_ff <= '0;
    end else if (wr_take && i_wb_adr == bldcs_pkg::ADR_IRQ_CLEAR) begin
      irq_status_ff <= (irq_status_ff & ~i_wb_dat[bldcs_pkg::EV_N-1:0]) | events;
    end else begin
      irq_status_ff <= irq_status_ff | events;
    end
  end

  assign o_irq = |(irq_status_ff & irq_enable_ff);

  // ****************************************
  // Start-up phase machine
  // ****************************************
  logic align_exit;
  logic ramp_exit;
  // Brake with the align capacitor cleared restarts the start-up
  assign restart = (wr_take && i_wb_adr == bldcs_pkg::ADR_CTRL
                    && i_wb_dat[bldcs_pkg::CTRL_RESTART_BIT])
                   || (brake && pins.align_cap_clear);
  assign align_exit = phase_ff == bldcs_pkg::PH_ALIGN && pins.align_done && !restart;
  assign ramp_exit = phase_ff == bldcs_pkg::PH_RAMP && pins.ramp_done && !restart;

  always_ff @(posedge i_core_clk) begin
    if (i_reset || restart) begin
      phase_ff <= bldcs_pkg::PH_ALIGN;
    end else begin
      case (phase_ff)
        bldcs_pkg::PH_ALIGN: begin
          if (pins.align_done) begin
            phase_ff <= bldcs_pkg::PH_RAMP;
          end
        end
        bldcs_pkg::PH_RAMP: begin
          if (pins.ramp_done) begin
            phase_ff <= bldcs_pkg::PH_RUN;
          end
        end
        bldcs_pkg::PH_RUN: phase_ff <= bldcs_pkg::PH_RUN;
        default: phase_ff <= bldcs_pkg::PH_ALIGN;
      endcase
    end
  end

  assign events = {brake && !brake_prev_ff, uv && !uv_prev_ff,
                   trip_rise && !brake, ramp_exit, align_exit};

  // ****************************************
  // Commutation state machine
  // ****************************************
  function automatic bldcs_pkg::bldcs_comm_t step(input bldcs_pkg::bldcs_comm_t c,
                                                  input logic fwd);
    case (c)
      bldcs_pkg::CS_A: step = fwd ? bldcs_pkg::CS_B : bldcs_pkg::CS_F;
      bldcs_pkg::CS_B: step = fwd ? bldcs_pkg::CS_C : bldcs_pkg::CS_A;
      bldcs_pkg::CS_C: step = fwd ? bldcs_pkg::CS_D : bldcs_pkg::CS_B;
      bldcs_pkg::CS_D: step = fwd ? bldcs_pkg::CS_E : bldcs_pkg::CS_C;
      bldcs_pkg::CS_E: step = fwd ? bldcs_pkg::CS_F : bldcs_pkg::CS_D;
      bldcs_pkg::CS_F: step = fwd ? bldcs_pkg::CS_A : bldcs_pkg::CS_E;
      default: step = bldcs_pkg::CS_A;
    endcase
  endfunction

  // Held at A during alignment so ramp opens on the first state
  always_ff @(posedge i_core_clk) begin
    if (i_reset || restart || phase_ff == bldcs_pkg::PH_ALIGN) begin
      comm_ff <= bldcs_pkg::CS_A;
    end else if (clk_rise) begin
      comm_ff <= step(comm_ff, pins.dir);
    end
  end

  // ****************************************
  // Cross-conduction interlock
  // ****************************************
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      lc_block_ff <= 1'b0;
    end else if (align_exit) begin
      lc_block_ff <= 1'b1;
    end else if (pins.hc_off) begin
      lc_block_ff <= 1'b0;
    end
  end

  // ****************************************
  // Current-limit one-shot
  // ****************************************
  logic oneshot_active;
  bldcs_oneshot #(
    .CYCLES(OFF_CYCLES)
  ) u_oneshot (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_fire(trip_rise && !brake),
    .o_active(oneshot_active)
  );
  assign limit_active = oneshot_active && !brake;

  // ****************************************
  // Output patterns and gating
  // ****************************************
  function automatic bldcs_pkg::bldcs_drive_t pattern(input bldcs_pkg::bldcs_comm_t c);
    case (c)
      bldcs_pkg::CS_A: pattern = '{low: 3'h4, high_n: 3'h6};
      bldcs_pkg::CS_B: pattern = '{low: 3'h4, high_n: 3'h5};
      bldcs_pkg::CS_C: pattern = '{low: 3'h1, high_n: 3'h5};
      bldcs_pkg::CS_D: pattern = '{low: 3'h1, high_n: 3'h3};
      bldcs_pkg::CS_E: pattern = '{low: 3'h2, high_n: 3'h3};
      bldcs_pkg::CS_F: pattern = '{low: 3'h2, high_n: 3'h6};
      default: pattern = bldcs_pkg::DRIVE_OFF;
    endcase
  endfunction

  function automatic logic [2:0] sense_sel(input bldcs_pkg::bldcs_comm_t c);
    case (c)
      bldcs_pkg::CS_A, bldcs_pkg::CS_D: sense_sel = 3'h2;
      bldcs_pkg::CS_B, bldcs_pkg::CS_E: sense_sel = 3'h1;
      default: sense_sel = 3'h4;
    endcase
  endfunction

  bldcs_pkg::bldcs_drive_t base;
  bldcs_pkg::bldcs_drive_t nxt_drive;
  bldcs_pkg::bldcs_drive_t drive_ff;
  logic nxt_bemf;
  logic bemf_ff;
  logic [2:0] sense_ff;
  logic uv_flag_n_ff;

  always_comb begin
    base = (phase_ff == bldcs_pkg::PH_ALIGN) ? bldcs_pkg::DRIVE_ALIGN : pattern(comm_ff);
    nxt_drive = base;
    nxt_drive.low = base.low & {3{pins.pwm}} & {3{!limit_active}};
    nxt_drive.low[2] = nxt_drive.low[2] && !lc_block_ff;
    if (uv) begin
      nxt_drive = bldcs_pkg::DRIVE_OFF;
    end else if (brake) begin
      nxt_drive = bldcs_pkg::DRIVE_BRAKE;
    end
    nxt_bemf = phase_ff == bldcs_pkg::PH_RUN;
  end

  // Registered so pins never glitch on combinational hazards
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      drive_ff <= bldcs_pkg::DRIVE_OFF;
      bemf_ff <= 1'b0;
      sense_ff <= 3'h0;
      uv_flag_n_ff <= 1'b1;
    end else begin
      drive_ff <= nxt_drive;
      bemf_ff <= nxt_bemf;
      sense_ff <= nxt_bemf ? sense_sel(comm_ff) : 3'h0;
      uv_flag_n_ff <= !uv;
    end
  end

  assign o_low_drive_phase_a = drive_ff.low[0];
  assign o_low_drive_phase_b = drive_ff.low[1];
  assign o_low_drive_phase_c = drive_ff.low[2];
  assign o_high_drive_phase_a_n = drive_ff.high_n[0];
  assign o_high_drive_phase_b_n = drive_ff.high_n[1];
  assign o_high_drive_phase_c_n = drive_ff.high_n[2];
  assign o_supply_low_flag_n = uv_flag_n_ff;
  assign o_bemf_enable = bemf_ff;
  assign o_bemf_sense_phase = sense_ff;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  sequence s_align_to_ramp;
    phase_ff == bldcs_pkg::PH_ALIGN ##1 phase_ff == bldcs_pkg::PH_RAMP;
  endsequence
  sequence s_quiet;
    !uv && !brake;
  endsequence

  a_reset_to_align: assert property (disable iff (1'b0) i_reset |=> phase_ff == bldcs_pkg::PH_ALIGN) else $error("reset not in align");
  a_align_pattern: assert property ((phase_ff == bldcs_pkg::PH_ALIGN) and s_quiet |=> drive_ff.high_n == 3'h2 && (drive_ff.low & 3'h5) == 3'h0) else $error("align pattern wrong");
  a_align_exit: assert property (align_exit |=> phase_ff == bldcs_pkg::PH_RAMP) else $error("align did not end");
  a_ramp_step: assert property (phase_ff != bldcs_pkg::PH_ALIGN && clk_rise && pins.dir && comm_ff == bldcs_pkg::CS_F && !restart |=> comm_ff == bldcs_pkg::CS_A) else $error("forward wrap wrong");
  a_ramp_no_bemf: assert property (phase_ff == bldcs_pkg::PH_RAMP |=> !o_bemf_enable && o_bemf_sense_phase == 3'h0) else $error("bemf on in ramp");
  a_ramp_exit: assert property (ramp_exit |=> phase_ff == bldcs_pkg::PH_RUN ##1 o_bemf_enable) else $error("ramp did not end");
  a_run_bemf: assert property (phase_ff == bldcs_pkg::PH_RUN && !restart |=> o_bemf_enable && o_bemf_sense_phase != 3'h0) else $error("bemf off in run");
  a_pwm_gate: assert property ((!pins.pwm) and s_quiet |=> drive_ff.low == 3'h0) else $error("pwm not gating");
  a_lc_interlock: assert property (s_align_to_ramp |-> lc_block_ff) else $error("lc not blocked");
  a_lc_held: assert property (lc_block_ff and s_quiet |=> !o_low_drive_phase_c) else $error("lc on while blocked");
  a_brake_drive: assert property (brake && !uv |=> drive_ff == bldcs_pkg::DRIVE_BRAKE) else $error("brake pattern wrong");
  a_brake_no_limit: assert property (brake |-> !limit_active) else $error("limit while braking");
  a_uv_flag: assert property (uv |=> !o_supply_low_flag_n) else $error("uv flag not low");
  a_uv_all_off: assert property (uv |=> drive_ff == bldcs_pkg::DRIVE_OFF) else $error("drivers on in uv");
  a_trip_fires: assert property (trip_rise && !brake && !oneshot_active ##1 s_quiet |=> drive_ff.low == 3'h0) else $error("trip did not cut lows");
  a_reverse_step: assert property (phase_ff != bldcs_pkg::PH_ALIGN && clk_rise && !pins.dir && comm_ff == bldcs_pkg::CS_A && !restart |=> comm_ff == bldcs_pkg::CS_F) else $error("reverse step wrong");
  a_fwd_table: assert property ((phase_ff != bldcs_pkg::PH_ALIGN && comm_ff == bldcs_pkg::CS_C) and s_quiet |=> drive_ff.high_n == 3'h5) else $error("state C highs wrong");
  a_restart_align: assert property (restart |=> phase_ff == bldcs_pkg::PH_ALIGN && comm_ff == bldcs_pkg::CS_A) else $error("restart ignored");

endmodule
`default_nettype wire

// ==== testbench/bldcs_stage_model.sv ====
// Half-bridge power stage stand-in for the sequencer bench.
// Assumes drive levels arrive on the core clock from the block under test.
`timescale 1ns/1ps
`default_nettype none
module bldcs_stage_model #(
  parameter int DLY = 20
) (
  input wire logic i_core_clk,
  input wire logic [2:0] i_low,
  input wire logic [2:0] i_high_n,
  output logic o_hc_off,
  output logic o_shoot
);
  int cnt = 0;
  initial o_shoot = 1'b0;
  // Slow turn-off of phase-C high switch, so the interlock really waits
  always @(posedge i_core_clk) begin
    if (i_high_n[2] !== 1'b1) cnt <= 0;
    else if (cnt < DLY) cnt <= cnt + 1;
    if ((i_low & ~i_high_n) != 3'h0) o_shoot <= 1'b1;
  end
  assign o_hc_off = (cnt >= DLY);
endmodule
`default_nettype wire

// ==== testbench/bldcs_top_tb.sv ====
// Self-checking bench for the start-up and commutation sequencer.
// Assumes a 100 MHz clock and a one-cycle Wishbone answer.
`timescale 1ns/1ps
`default_nettype none
module bldcs_top_tb;
  logic clk, rst, cyc, stb, we, ack, irq, brk_n, dir, al, rp, hcoff, trip, uv, pwm, cc, cap;
  logic la, lb, lc, ha_n, hb_n, hc_n, flag_n, bemf, shoot;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0] sel;
  logic [2:0] sense;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [5:0] drv;
  // Forward table, low bits above active-low high bits
  logic [5:0] pat [6] = '{6'h26, 6'h25, 6'h0D, 6'h0B, 6'h13, 6'h16};
  assign drv = {lc, lb, la, hc_n, hb_n, ha_n};

  bldcs_top #(.OFF_CYCLES(20)) i_dut (.i_core_clk(clk), .i_reset(rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_irq(irq), .i_brake_n(brk_n), .i_dir(dir),
    .i_align_done(al), .i_ramp_done(rp), .i_hc_off(hcoff), .i_current_trip(trip),
    .i_supply_low(uv), .i_pwm(pwm), .i_commutation_clock(cc), .i_align_cap_clear(cap),
    .o_low_drive_phase_a(la), .o_low_drive_phase_b(lb), .o_low_drive_phase_c(lc),
    .o_high_drive_phase_a_n(ha_n), .o_high_drive_phase_b_n(hb_n),
    .o_high_drive_phase_c_n(hc_n), .o_supply_low_flag_n(flag_n), .o_bemf_enable(bemf),
    .o_bemf_sense_phase(sense));

  bldcs_stage_model i_stage (.i_core_clk(clk), .i_low({lc, lb, la}),
    .i_high_n({hc_n, hb_n, ha_n}), .o_hc_off(hcoff), .o_shoot(shoot));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task cyc_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Single classic cycle; held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (k >= 50) begin
      n_mismatch++;
      stop_test();
    end
  endtask

  task status(input logic [1:0] ph, input logic [2:0] cs);
    wb(1'b0, 8'h04, 32'h0);
    chk("phase", q[1:0], ph);
    chk("comm_state", q[4:2], cs);
  endtask

  // Pulses held long enough to pass the pin filter
  task step();
    cc <= 1'b1;
    cyc_n(6);
    cc <= 1'b0;
    cyc_n(6);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; wdat = 32'h0; sel = 4'hF;
    brk_n = 1'b1; dir = 1'b1; al = 1'b0; rp = 1'b0; trip = 1'b0; uv = 1'b0;
    pwm = 1'b1; cc = 1'b0; cap = 1'b0;
    cyc_n(2);
    rst <= 1'b0;
    cyc_n(8);
    chk("drive_align", drv, 6'h12);
    status(2'h0, 3'h0);
    step();
    chk("align_hold", drv, 6'h12);
    wb(1'b1, 8'h10, 32'h1F);
    $display("end align test");
    al <= 1'b1;
    cyc_n(8);
    status(2'h1, 3'h0);
    chk("lc_blocked", drv, 6'h06);
    chk("bemf_ramp", {sense, bemf}, 32'h0);
    cyc_n(30);
    chk("lc_released", drv, pat[0]);
    chk("irq_on", irq, 1'b1);
    for (int i = 1; i < 7; i++) begin
      step();
      chk("ramp_step", drv, pat[i % 6]);
    end
    status(2'h1, 3'h0);
    pwm <= 1'b0;
    cyc_n(8);
    chk("pwm_gate", drv, {3'b000, pat[0][2:0]});
    pwm <= 1'b1;
    trip <= 1'b1;
    cyc_n(8);
    trip <= 1'b0;
    chk("trip_off", drv[5:3], 3'b000);
    cyc_n(25);
    chk("trip_end", drv, pat[0]);
    $display("end ramp test");
    rp <= 1'b1;
    cyc_n(8);
    status(2'h2, 3'h0);
    chk("bemf_run", bemf, 1'b1);
    step();
    chk("run_step", drv, pat[1]);
    chk("sense_phase", sense, 3'b001);
    brk_n <= 1'b0;
    cyc_n(8);
    chk("brake", drv, 6'h3F);
    trip <= 1'b1;
    cyc_n(8);
    trip <= 1'b0;
    chk("brake_trip", drv, 6'h3F);
    uv <= 1'b1;
    cyc_n(8);
    chk("uv_off", drv, 6'h07);
    chk("uv_flag", flag_n, 1'b0);
    uv <= 1'b0;
    cyc_n(8);
    chk("uv_gone", flag_n, 1'b1);
    $display("end run test");
    al <= 1'b0;
    rp <= 1'b0;
    cap <= 1'b1;
    cyc_n(8);
    dir <= 1'b0;
    cap <= 1'b0;
    brk_n <= 1'b1;
    cyc_n(8);
    status(2'h0, 3'h0);
    chk("restart", drv, 6'h12);
    al <= 1'b1;
    cyc_n(8);
    step();
    status(2'h1, 3'h5);
    chk("reverse", drv, pat[5]);
    $display("end reverse test");
    wb(1'b0, 8'h08, 32'h0);
    chk("irq_sticky", q, 32'h1F);
    wb(1'b1, 8'h10, 32'h0);
    cyc_n(1);
    chk("irq_masked", irq, 1'b0);
    wb(1'b1, 8'h0C, 32'h1F);
    wb(1'b0, 8'h08, 32'h0);
    chk("irq_clear", q, 32'h0);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", q, 32'h0);
    chk("no_shoot", shoot, 1'b0);
    $display("end register test");
    stop_test();
  end
endmodule
`default_nettype wire
